// ---- rtl/fpmc_top.sv ----
// Front panel mode controller with AXI4-Lite host access
//
// Functional notes
// - Exactly one mode is held; each mode button enters its own mode.
// - Input button in input mode swaps channel; from output it only enters.
// - Knob switch in input mode also swaps the selected channel.
// - Source option flips selected channel between mic and line.
// - Plug detect forces channel one to instrument jack; only channel one.
// - Each channel has exactly one of mic, line, instrument active.
// - In input mode knob rotation raises or lowers selected channel gain.
// - Six option flags per channel; option buttons change them only in input mode.
// - Option lamp bright when on, dim when off, dark when unavailable.
// - In output mode option presses are ignored and lamps are dark.
// - Output button in output mode swaps speaker and phones.
// - In output mode rotation changes only the selected output volume.
// - Knob switch with speaker selected toggles mute; phones never muted.
// - Mute with speaker selected turns ring and speaker lamp red.
// - Ring shows gain of selected channel or volume of selected output.
// - Pad is available only for the mic source.
// - Phantom power is available only for the mic source.
// - Filter flag enables the rumble high-pass on that channel.
// - Polarity flag inverts the channel's input sign.
// - With stereo pair on, input changes apply to both channels.
// - Stereo pair cannot be switched on while the plug is detected.
`timescale 1ns/1ns
module fpmc_top (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // Panel pins, asynchronous to aclk
  input  wire logic        input_btn,
  input  wire logic        output_btn,
  input  wire logic        knob_sw,
  input  wire logic        knob_cw,
  input  wire logic        knob_ccw,
  input  wire logic [5:0]  opt_btn,
  input  wire logic        inst_detect,
  // AXI4-Lite slave
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Lamps
  output logic             channel_one_lamp,
  output logic             channel_two_lamp,
  output logic             src_mic_lamp,
  output logic             src_line_lamp,
  output logic             instrument_jack_lamp,
  output logic             speaker_lamp,
  output logic             speaker_lamp_red,
  output logic             phones_lamp,
  output logic [5:0]       opt_bright,
  output logic [5:0]       opt_dim,
  output logic [7:0]       ring_level,
  output logic             ring_red,
  // Audio path controls, index 0 is channel one
  output logic [1:0]       route_mic,
  output logic [1:0]       route_line,
  output logic             route_instrument,
  output logic [1:0]       phantom_power_enable,
  output logic [1:0]       pad_enable,
  output logic [1:0]       rumble_cut_enable,
  output logic [1:0]       polarity_invert,
  output logic [7:0]       gain_ch1,
  output logic [7:0]       gain_ch2,
  output logic [7:0]       speaker_volume,
  output logic [7:0]       phones_volume,
  output logic             speaker_mute
);

  typedef struct packed {
    logic [fpmc_pkg::NUM_PIN-1:0]            sy1;
    logic [fpmc_pkg::NUM_PIN-1:0]            sy2;
    logic [fpmc_pkg::NUM_PIN-1:0]            prev;
    fpmc_pkg::fpmc_mode_type                 mode;
    logic                                    sel_ch;
    logic                                    sel_out;
    logic                                    mute;
    logic [1:0][fpmc_pkg::NUM_OPT-1:0]       opt;
    logic [1:0][7:0]                         gain;
    logic [7:0]                              vol_spk;
    logic [7:0]                              vol_hp;
    logic                                    aw_full;
    logic [7:0]                              aw_addr;
    logic                                    w_full;
    logic [31:0]                             w_data;
    logic [3:0]                              w_strb;
    logic                                    awready;
    logic                                    wready;
    logic                                    bvalid;
    logic [1:0]                              bresp;
    logic                                    arready;
    logic                                    rvalid;
    logic [31:0]                             rdata;
    logic [1:0]                              rresp;
    logic                                    ch1_lamp;
    logic                                    ch2_lamp;
    logic                                    mic_lamp;
    logic                                    line_lamp;
    logic                                    inst_lamp;
    logic                                    spk_lamp;
    logic                                    spk_red;
    logic                                    hp_lamp;
    logic [5:0]                              bright;
    logic [5:0]                              dim;
    logic [7:0]                              ring;
    logic                                    ring_red;
    logic [1:0]                              r_mic;
    logic [1:0]                              r_line;
    logic                                    r_inst;
    logic [1:0]                              r_phant;
    logic [1:0]                              r_pad;
    logic [1:0]                              r_hpf;
    logic [1:0]                              r_pol;
  } fpmc_state_type;

  fpmc_state_type s_r;
  fpmc_state_type s_nxt;

  // Saturating level steps
  function automatic logic [7:0] lvl_up(input logic [7:0] v);
    lvl_up = (v == fpmc_pkg::LVL_MAX) ? v : v + fpmc_pkg::LVL_STEP;
  endfunction

  function automatic logic [7:0] lvl_dn(input logic [7:0] v);
    lvl_dn = (v == fpmc_pkg::LVL_MIN) ? v : v - fpmc_pkg::LVL_STEP;
  endfunction

  // Whole next state: sync, panel events, host access, lamps
  always_comb begin
    logic [10:0] press;
    logic        det;
    logic        sel;
    logic        linked;
    logic        turn_up;
    logic        turn_dn;
    logic [1:0]  inst;
    logic [1:0]  mic;
    logic [5:0]  avail;
    logic [7:0]  g;
    logic        wr_go;
    logic [31:0] rd;
    logic [1:0]  rsp;
    press   = '0;
    det     = 1'b0;
    sel     = 1'b0;
    linked  = 1'b0;
    turn_up = 1'b0;
    turn_dn = 1'b0;
    inst    = '0;
    mic     = '0;
    avail   = '0;
    g       = '0;
    wr_go   = 1'b0;
    rd      = '0;
    rsp     = fpmc_pkg::RESP_OKAY;
    s_nxt   = s_r;

    // Two-flop sync; edges are taken on the second stage only
    s_nxt.sy1  = {inst_detect, opt_btn, knob_ccw, knob_cw, knob_sw,
                  output_btn, input_btn};
    s_nxt.sy2  = s_r.sy1;
    s_nxt.prev = s_r.sy2;
    press      = s_r.sy2[10:0] & ~s_r.prev[10:0];
    det        = s_r.sy2[fpmc_pkg::PIN_DET];
    sel        = s_r.sel_ch;
    linked     = s_r.opt[0][fpmc_pkg::OPT_LINK];
    // Both directions at once cancel rather than guess
    turn_up    = press[fpmc_pkg::PIN_CW] & ~press[fpmc_pkg::PIN_CCW];
    turn_dn    = press[fpmc_pkg::PIN_CCW] & ~press[fpmc_pkg::PIN_CW];

    // Effective source per channel
    inst = {1'b0, det};
    for (int c = 0; c < 2; c++) begin
      mic[c] = ~inst[c] & ~s_r.opt[c][fpmc_pkg::OPT_SRC];
    end

    // Availability of each option on the selected channel
    avail                       = 6'h3f;
    avail[fpmc_pkg::OPT_SRC]    = ~inst[sel];
    avail[fpmc_pkg::OPT_PHANT]  = mic[sel];
    avail[fpmc_pkg::OPT_PAD]    = mic[sel];
    avail[fpmc_pkg::OPT_LINK]   = ~det;

    // Panel events; mode buttons take priority over the rest
    if (press[fpmc_pkg::PIN_INBTN]) begin
      if (s_r.mode == fpmc_pkg::FPMC_MODE_INPUT) begin
        s_nxt.sel_ch = ~s_r.sel_ch;
      end
      s_nxt.mode = fpmc_pkg::FPMC_MODE_INPUT;
    end else if (press[fpmc_pkg::PIN_OUTBTN]) begin
      if (s_r.mode == fpmc_pkg::FPMC_MODE_OUTPUT) begin
        s_nxt.sel_out = ~s_r.sel_out;
      end
      s_nxt.mode = fpmc_pkg::FPMC_MODE_OUTPUT;
    end else if (s_r.mode == fpmc_pkg::FPMC_MODE_INPUT) begin
      if (press[fpmc_pkg::PIN_KSW]) begin
        s_nxt.sel_ch = ~s_r.sel_ch;
      end
      // Gain of the selected channel, mirrored when paired
      g = s_r.gain[sel];
      if (turn_up) begin
        g = lvl_up(g);
      end else if (turn_dn) begin
        g = lvl_dn(g);
      end
      s_nxt.gain[sel] = g;
      if (linked) begin
        s_nxt.gain[~sel] = g;
      end
      // Option buttons act on the selected channel, and on both when paired
      for (int k = 0; k < fpmc_pkg::NUM_OPT; k++) begin
        if (press[fpmc_pkg::PIN_OPT0 + k] && avail[k]) begin
          if (k == fpmc_pkg::OPT_LINK) begin
            // Pair flag is kept equal on both channels
            s_nxt.opt[0][k] = ~linked;
            s_nxt.opt[1][k] = ~linked;
          end else begin
            s_nxt.opt[sel][k] = ~s_r.opt[sel][k];
            if (linked) begin
              s_nxt.opt[~sel][k] = ~s_r.opt[sel][k];
            end
          end
        end
      end
    end else begin
      // Output mode: option buttons fall through untouched
      if (press[fpmc_pkg::PIN_KSW] && !s_r.sel_out) begin
        s_nxt.mute = ~s_r.mute;
      end
      if (s_r.sel_out) begin
        if (turn_up) begin
          s_nxt.vol_hp = lvl_up(s_r.vol_hp);
        end else if (turn_dn) begin
          s_nxt.vol_hp = lvl_dn(s_r.vol_hp);
        end
      end else begin
        if (turn_up) begin
          s_nxt.vol_spk = lvl_up(s_r.vol_spk);
        end else if (turn_dn) begin
          s_nxt.vol_spk = lvl_dn(s_r.vol_spk);
        end
      end
    end

    // Write address and data are taken independently
    if (s_axi_awvalid && s_r.awready) begin
      s_nxt.aw_full = 1'b1;
      s_nxt.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_r.wready) begin
      s_nxt.w_full = 1'b1;
      s_nxt.w_data = s_axi_wdata;
      s_nxt.w_strb = s_axi_wstrb;
    end
    if (s_r.bvalid && s_axi_bready) begin
      s_nxt.bvalid = 1'b0;
    end
    wr_go = s_r.aw_full & s_r.w_full & ~s_r.bvalid;

    // Host writes land after panel events, so the host wins a tie
    if (wr_go) begin
      s_nxt.aw_full = 1'b0;
      s_nxt.w_full  = 1'b0;
      s_nxt.bvalid  = 1'b1;
      s_nxt.bresp   = fpmc_pkg::RESP_OKAY;
      unique case (s_r.aw_addr)
        fpmc_pkg::OFS_CTRL: begin
          if (s_r.w_strb[0]) begin
            s_nxt.mode    = fpmc_pkg::fpmc_mode_type'(
                              s_r.w_data[fpmc_pkg::CTRL_MODE]);
            s_nxt.sel_ch  = s_r.w_data[fpmc_pkg::CTRL_CH];
            s_nxt.sel_out = s_r.w_data[fpmc_pkg::CTRL_OUT];
            s_nxt.mute    = s_r.w_data[fpmc_pkg::CTRL_MUTE];
          end
        end
        fpmc_pkg::OFS_OPT1, fpmc_pkg::OFS_OPT2: begin
          if (s_r.w_strb[0]) begin
            g = {7'h00, s_r.aw_addr == fpmc_pkg::OFS_OPT2};
            s_nxt.opt[g[0]] = s_r.w_data[5:0];
            // Pair flag copied to both, still refused under a plug
            s_nxt.opt[0][fpmc_pkg::OPT_LINK] =
              s_r.w_data[fpmc_pkg::OPT_LINK] & ~det;
            s_nxt.opt[1][fpmc_pkg::OPT_LINK] =
              s_r.w_data[fpmc_pkg::OPT_LINK] & ~det;
          end
        end
        fpmc_pkg::OFS_GAIN: begin
          if (s_r.w_strb[0]) begin
            s_nxt.gain[0] = s_r.w_data[7:0];
          end
          if (s_r.w_strb[1]) begin
            s_nxt.gain[1] = s_r.w_data[15:8];
          end
        end
        fpmc_pkg::OFS_VOL: begin
          if (s_r.w_strb[0]) begin
            s_nxt.vol_spk = s_r.w_data[7:0];
          end
          if (s_r.w_strb[1]) begin
            s_nxt.vol_hp = s_r.w_data[15:8];
          end
        end
        fpmc_pkg::OFS_STATUS: begin
          // Read-only; write is accepted and dropped
        end
        default: begin
          s_nxt.bresp = fpmc_pkg::RESP_SLVERR;
        end
      endcase
    end

    // Pair cannot survive an inserted plug
    if (det) begin
      s_nxt.opt[0][fpmc_pkg::OPT_LINK] = 1'b0;
      s_nxt.opt[1][fpmc_pkg::OPT_LINK] = 1'b0;
    end

    // Read channel; data is captured at the address handshake
    if (s_r.rvalid && s_axi_rready) begin
      s_nxt.rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_r.arready) begin
      unique case (s_axi_araddr)
        fpmc_pkg::OFS_CTRL: begin
          rd[fpmc_pkg::CTRL_MODE] = s_r.mode;
          rd[fpmc_pkg::CTRL_CH]   = s_r.sel_ch;
          rd[fpmc_pkg::CTRL_OUT]  = s_r.sel_out;
          rd[fpmc_pkg::CTRL_MUTE] = s_r.mute;
        end
        fpmc_pkg::OFS_OPT1:   rd[5:0]  = s_r.opt[0];
        fpmc_pkg::OFS_OPT2:   rd[5:0]  = s_r.opt[1];
        fpmc_pkg::OFS_GAIN:   rd[15:0] = {s_r.gain[1], s_r.gain[0]};
        fpmc_pkg::OFS_VOL:    rd[15:0] = {s_r.vol_hp, s_r.vol_spk};
        fpmc_pkg::OFS_STATUS: rd[4:0]  = {mic, s_r.sy2[fpmc_pkg::PIN_DET],
                                          s_r.prev[fpmc_pkg::PIN_DET],
                                          det};
        default: begin
          rsp = fpmc_pkg::RESP_SLVERR;
        end
      endcase
      s_nxt.rvalid = 1'b1;
      s_nxt.rdata  = rd;
      s_nxt.rresp  = rsp;
    end

    // Each ready only while its own slot holds nothing and no response is pending
    s_nxt.awready = ~s_nxt.aw_full & ~s_nxt.bvalid;
    s_nxt.wready  = ~s_nxt.w_full & ~s_nxt.bvalid;
    s_nxt.arready = ~s_nxt.rvalid;

    // Lamps and routing follow the next state, so they align with it
    inst = {1'b0, s_nxt.sy2[fpmc_pkg::PIN_DET]};
    for (int c = 0; c < 2; c++) begin
      mic[c]            = ~inst[c] & ~s_nxt.opt[c][fpmc_pkg::OPT_SRC];
      s_nxt.r_mic[c]    = mic[c];
      s_nxt.r_line[c]   = ~inst[c] & s_nxt.opt[c][fpmc_pkg::OPT_SRC];
      s_nxt.r_phant[c]  = mic[c] & s_nxt.opt[c][fpmc_pkg::OPT_PHANT];
      s_nxt.r_pad[c]    = mic[c] & s_nxt.opt[c][fpmc_pkg::OPT_PAD];
      s_nxt.r_hpf[c]    = s_nxt.opt[c][fpmc_pkg::OPT_FILTER];
      s_nxt.r_pol[c]    = s_nxt.opt[c][fpmc_pkg::OPT_POL];
    end
    s_nxt.r_inst    = inst[0];
    sel             = s_nxt.sel_ch;
    s_nxt.ch1_lamp  = ~sel;
    s_nxt.ch2_lamp  = sel;
    s_nxt.mic_lamp  = s_nxt.r_mic[sel];
    s_nxt.line_lamp = s_nxt.r_line[sel];
    s_nxt.inst_lamp = inst[sel];

    avail                      = 6'h3f;
    avail[fpmc_pkg::OPT_SRC]   = ~inst[sel];
    avail[fpmc_pkg::OPT_PHANT] = mic[sel];
    avail[fpmc_pkg::OPT_PAD]   = mic[sel];
    avail[fpmc_pkg::OPT_LINK]  = ~inst[0];
    if (s_nxt.mode == fpmc_pkg::FPMC_MODE_INPUT) begin
      s_nxt.bright = avail & s_nxt.opt[sel];
      s_nxt.dim    = avail & ~s_nxt.opt[sel];
      s_nxt.ring   = s_nxt.gain[sel];
      s_nxt.spk_lamp = 1'b0;
      s_nxt.hp_lamp  = 1'b0;
    end else begin
      s_nxt.bright = '0;
      s_nxt.dim    = '0;
      s_nxt.ring   = s_nxt.sel_out ? s_nxt.vol_hp : s_nxt.vol_spk;
      s_nxt.spk_lamp = ~s_nxt.sel_out;
      s_nxt.hp_lamp  = s_nxt.sel_out;
    end
    s_nxt.spk_red  = s_nxt.spk_lamp & s_nxt.mute;
    s_nxt.ring_red = s_nxt.spk_lamp & s_nxt.mute;
  end

  // State register; reset clears every field, then loads gains and volumes
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_r         <= '0;
      s_r.gain    <= {fpmc_pkg::GAIN_RST, fpmc_pkg::GAIN_RST};
      s_r.vol_spk <= fpmc_pkg::VOL_RST;
      s_r.vol_hp  <= fpmc_pkg::VOL_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  // Outputs straight from the state flops
  assign s_axi_awready        = s_r.awready;
  assign s_axi_wready         = s_r.wready;
  assign s_axi_bresp          = s_r.bresp;
  assign s_axi_bvalid         = s_r.bvalid;
  assign s_axi_arready        = s_r.arready;
  assign s_axi_rdata          = s_r.rdata;
  assign s_axi_rresp          = s_r.rresp;
  assign s_axi_rvalid         = s_r.rvalid;
  assign channel_one_lamp     = s_r.ch1_lamp;
  assign channel_two_lamp     = s_r.ch2_lamp;
  assign src_mic_lamp         = s_r.mic_lamp;
  assign src_line_lamp        = s_r.line_lamp;
  assign instrument_jack_lamp = s_r.inst_lamp;
  assign speaker_lamp         = s_r.spk_lamp;
  assign speaker_lamp_red     = s_r.spk_red;
  assign phones_lamp          = s_r.hp_lamp;
  assign opt_bright           = s_r.bright;
  assign opt_dim              = s_r.dim;
  assign ring_level           = s_r.ring;
  assign ring_red             = s_r.ring_red;
  assign route_mic            = s_r.r_mic;
  assign route_line           = s_r.r_line;
  assign route_instrument     = s_r.r_inst;
  assign phantom_power_enable = s_r.r_phant;
  assign pad_enable           = s_r.r_pad;
  assign rumble_cut_enable    = s_r.r_hpf;
  assign polarity_invert      = s_r.r_pol;
  assign gain_ch1             = s_r.gain[0];
  assign gain_ch2             = s_r.gain[1];
  assign speaker_volume       = s_r.vol_spk;
  assign phones_volume        = s_r.vol_hp;
  // Mute only ever reaches the speaker path
  assign speaker_mute         = s_r.mute;

endmodule

// ---- rtl/fpmc_pkg.sv ----
// Shared constants and types for the front panel mode controller
package fpmc_pkg;

  // Panel modes
  typedef enum logic {
    FPMC_MODE_INPUT,
    FPMC_MODE_OUTPUT
  } fpmc_mode_type;

  // Register bus geometry
  localparam int ADDR_W   = 8;
  localparam int DATA_W   = 32;

  // Register byte offsets
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_OPT1   = 8'h04;
  localparam logic [7:0] OFS_OPT2   = 8'h08;
  localparam logic [7:0] OFS_GAIN   = 8'h0c;
  localparam logic [7:0] OFS_VOL    = 8'h10;
  localparam logic [7:0] OFS_STATUS = 8'h14;

  // Control register fields
  localparam int CTRL_MODE  = 0;
  localparam int CTRL_CH    = 1;
  localparam int CTRL_OUT   = 2;
  localparam int CTRL_MUTE  = 3;

  // Option flag positions inside each channel's six flags
  localparam int OPT_SRC    = 0;
  localparam int OPT_FILTER = 1;
  localparam int OPT_PHANT  = 2;
  localparam int OPT_PAD    = 3;
  localparam int OPT_POL    = 4;
  localparam int OPT_LINK   = 5;
  localparam int NUM_OPT    = 6;

  // Pin vector positions
  localparam int PIN_INBTN  = 0;
  localparam int PIN_OUTBTN = 1;
  localparam int PIN_KSW    = 2;
  localparam int PIN_CW     = 3;
  localparam int PIN_CCW    = 4;
  localparam int PIN_OPT0   = 5;
  localparam int PIN_DET    = 11;
  localparam int NUM_PIN    = 12;

  // Values after reset, level limits and level step
  localparam logic [7:0] GAIN_RST = 8'h40;
  localparam logic [7:0] VOL_RST  = 8'h40;
  localparam logic [7:0] LVL_MAX  = 8'hff;
  localparam logic [7:0] LVL_MIN  = 8'h00;
  localparam logic [7:0] LVL_STEP = 8'h01;

  // Bus responses
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

endpackage

// ---- dv/fpmc_properties.sv ----
// Port-level checks for the front panel controller
`timescale 1ns/1ns
module fpmc_checker (
  input wire logic       aclk,
  input wire logic       aresetn,
  input wire logic       inst_detect,
  input wire logic       channel_one_lamp,
  input wire logic       channel_two_lamp,
  input wire logic       src_mic_lamp,
  input wire logic       src_line_lamp,
  input wire logic       instrument_jack_lamp,
  input wire logic       speaker_lamp,
  input wire logic       phones_lamp,
  input wire logic       ring_red,
  input wire logic       speaker_mute,
  input wire logic       route_instrument,
  input wire logic [1:0] route_mic,
  input wire logic [1:0] pad_enable,
  input wire logic [1:0] phantom_power_enable,
  input wire logic [5:0] opt_bright,
  input wire logic [5:0] opt_dim,
  input wire logic [7:0] ring_level,
  input wire logic [7:0] speaker_volume
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Lamps still read zero on the first edge after reset
  logic live_r;
  always_ff @(posedge aclk) live_r <= aresetn;
  // Plug held long enough to pass the synchroniser
  sequence plug_s;
    inst_detect [*5];
  endsequence
  sel_lamp_a: assert property (
    live_r |-> channel_one_lamp ^ channel_two_lamp) else $error("ch lamps");
  src_hot_a: assert property (
    live_r |-> $onehot({src_mic_lamp, src_line_lamp, instrument_jack_lamp}))
    else $error("source lamps");
  plug_force_a: assert property (
    plug_s |-> route_instrument && !route_mic[0]) else $error("plug route");
  avail_gate_a: assert property (
    ((pad_enable | phantom_power_enable) & ~route_mic) == 2'b00)
    else $error("mic only option");
  lamp_dark_a: assert property (
    speaker_lamp || phones_lamp |-> {opt_bright, opt_dim} == 12'h000)
    else $error("option lamps lit");
  bright_dim_a: assert property (
    (opt_bright & opt_dim) == 6'h00) else $error("bright and dim");
  mute_red_a: assert property (
    ring_red == (speaker_lamp && speaker_mute)) else $error("ring red");
  ring_vol_a: assert property (
    speaker_lamp |-> ring_level == speaker_volume) else $error("ring vol");
endmodule
bind fpmc_top fpmc_checker chk_i (.*);

// ---- dv/fpmc_panel_model.sv ----
// Behavioural front panel: buttons, level knob and instrument plug
`timescale 1ns/1ns
module fpmc_panel_model (
  input  wire logic       aclk,
  output logic            input_btn,
  output logic            output_btn,
  output logic            knob_sw,
  output logic            knob_cw,
  output logic            knob_ccw,
  output logic [5:0]      opt_btn,
  output logic            inst_detect
);
  logic [11:0] pin_r = 12'h000;
  // Pin vector fanned out to the panel wires
  assign input_btn = pin_r[fpmc_pkg::PIN_INBTN];
  assign output_btn = pin_r[fpmc_pkg::PIN_OUTBTN];
  assign knob_sw = pin_r[fpmc_pkg::PIN_KSW];
  assign knob_cw = pin_r[fpmc_pkg::PIN_CW];
  assign knob_ccw = pin_r[fpmc_pkg::PIN_CCW];
  assign opt_btn = pin_r[fpmc_pkg::PIN_OPT0 +: 6];
  assign inst_detect = pin_r[fpmc_pkg::PIN_DET];
  // Press held past the synchroniser, then a gap before the next one
  task automatic press(input int k);
    @(posedge aclk);
    pin_r[k] <= 1'b1;
    repeat (2) @(posedge aclk);
    pin_r[k] <= 1'b0;
    repeat (5) @(posedge aclk);
  endtask
  task automatic plug(input logic v);
    @(posedge aclk);
    pin_r[fpmc_pkg::PIN_DET] <= v;
    repeat (5) @(posedge aclk);
  endtask
endmodule

// ---- dv/fpmc_top_tb.sv ----
// Self-checking bench for the front panel controller
`timescale 1ns/1ns
module fpmc_top_tb;
  localparam int OPT = fpmc_pkg::PIN_OPT0;
  localparam logic [7:0] G = fpmc_pkg::GAIN_RST;
  localparam logic [7:0] V = fpmc_pkg::VOL_RST;
  logic aclk, aresetn, input_btn, output_btn, knob_sw, knob_cw, knob_ccw;
  logic inst_detect, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
  logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
  logic s_axi_arready, s_axi_rvalid, s_axi_rready, channel_one_lamp;
  logic channel_two_lamp, src_mic_lamp, src_line_lamp, speaker_lamp;
  logic instrument_jack_lamp, speaker_lamp_red, phones_lamp, ring_red;
  logic route_instrument, speaker_mute;
  logic [1:0]  s_axi_bresp, s_axi_rresp, route_mic, route_line, rsp;
  logic [1:0]  pad_enable, phantom_power_enable, rumble_cut_enable;
  logic [1:0]  polarity_invert;
  logic [3:0]  s_axi_wstrb;
  logic [5:0]  opt_btn, opt_bright, opt_dim;
  logic [7:0]  s_axi_awaddr, s_axi_araddr, ring_level, gain_ch1, gain_ch2;
  logic [7:0]  speaker_volume, phones_volume;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  int          err_total, check_count;
  fpmc_top dut (.*);
  fpmc_panel_model pm (.*);
  // Free-running system clock
  initial begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end
  task automatic stop_test();
    if (err_total == 0 && check_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] exp, got);
    check_count++;
    if (got !== exp) begin
      $display("[ERR] %s exp %h got %h", nm, exp, got);
      err_total++;
    end
  endtask
  // Bus waits are bounded; running out ends the run
  task automatic tmo(input int n);
    if (n >= 50) begin
      chk("bus wait", 32'h1, 32'h0);
      stop_test();
    end
  endtask
  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge aclk); // Keeps a call from re-raising what the last lowered
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    s_axi_bready <= 1'b0;
    rsp = s_axi_bresp;
    tmo(n);
  endtask
  task automatic axr(input logic [7:0] a);
    int n;
    @(posedge aclk); // Same guard as the write task
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    s_axi_rready <= 1'b0;
    rd = s_axi_rdata;
    rsp = s_axi_rresp;
    tmo(n);
  endtask
  // Main sequence: panel presses and host accesses with expectations
  initial begin
    aresetn = 1'b0;
    err_total = 0;
    check_count = 0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
    {s_axi_arvalid, s_axi_rready, s_axi_wstrb} = 6'h0f;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    axr(fpmc_pkg::OFS_CTRL);
    chk("ctrl", 32'h0, rd);
    axr(fpmc_pkg::OFS_GAIN);
    chk("gain rst", {16'h0, G, G}, rd);
    chk("mic rst", 1'b1, src_mic_lamp);
    axr(8'h20);
    chk("unmapped", fpmc_pkg::RESP_SLVERR, rsp);
    pm.press(fpmc_pkg::PIN_INBTN);
    chk("ch2", 1'b1, channel_two_lamp);
    pm.press(fpmc_pkg::PIN_KSW);
    chk("ch1", 1'b1, channel_one_lamp);
    repeat (2) pm.press(fpmc_pkg::PIN_CW);
    pm.press(fpmc_pkg::PIN_CCW);
    chk("gains", {G + 8'h01, G}, {gain_ch1, gain_ch2});
    chk("ring", G + 8'h01, ring_level);
    pm.press(OPT + fpmc_pkg::OPT_SRC);
    chk("line", 3'b101, {src_line_lamp, route_line});
    pm.press(OPT + fpmc_pkg::OPT_PAD);
    pm.press(OPT + fpmc_pkg::OPT_SRC);
    chk("pad", 2'b01, {opt_bright[3], opt_dim[3]});
    pm.press(OPT + fpmc_pkg::OPT_FILTER);
    pm.press(OPT + fpmc_pkg::OPT_PHANT);
    pm.press(OPT + fpmc_pkg::OPT_POL);
    chk("flags", 6'h15, {rumble_cut_enable, phantom_power_enable,
        polarity_invert});
    pm.plug(1'b1);
    chk("inst", 3'b100,
        {instrument_jack_lamp, phantom_power_enable});
    pm.press(OPT + fpmc_pkg::OPT_LINK);
    axr(fpmc_pkg::OFS_OPT1);
    chk("pair blocked", 32'h0, rd & 32'h20);
    pm.plug(1'b0);
    pm.press(OPT + fpmc_pkg::OPT_LINK);
    pm.press(fpmc_pkg::PIN_CW);
    chk("pair gain", {G + 8'h02, G + 8'h02}, {gain_ch1, gain_ch2});
    pm.plug(1'b1);
    axr(fpmc_pkg::OFS_OPT2);
    chk("pair clear", 32'h0, rd & 32'h20);
    pm.press(fpmc_pkg::PIN_OUTBTN);
    chk("speaker", 1'b1, speaker_lamp);
    pm.press(OPT + fpmc_pkg::OPT_FILTER);
    chk("filter kept", 2'b01, rumble_cut_enable);
    pm.press(fpmc_pkg::PIN_CW);
    chk("spk vol", {V + 8'h01, G + 8'h02},
        {speaker_volume, gain_ch1});
    pm.press(fpmc_pkg::PIN_KSW);
    chk("mute", 3'b111,
        {speaker_mute, ring_red, speaker_lamp_red});
    pm.press(fpmc_pkg::PIN_OUTBTN);
    chk("phones", 1'b1, phones_lamp);
    pm.press(fpmc_pkg::PIN_KSW);
    pm.press(fpmc_pkg::PIN_CW);
    chk("ph vol", {V + 8'h01, V + 8'h01},
        {phones_volume, ring_level});
    chk("mute held", 1'b1, speaker_mute);
    axw(fpmc_pkg::OFS_GAIN, 32'h0000_1234);
    chk("host gain", 16'h1234, {gain_ch2, gain_ch1});
    chk("gain resp", fpmc_pkg::RESP_OKAY, rsp);
    pm.press(fpmc_pkg::PIN_INBTN);
    chk("enter only", 1'b1, channel_one_lamp);
    axw(fpmc_pkg::OFS_CTRL, 32'h0000_0009);
    chk("ctrl wr", 3'b110, {speaker_lamp, ring_red, phones_lamp});
    axw(8'h24, 32'h0);
    chk("wr unmapped", fpmc_pkg::RESP_SLVERR, rsp);
    axr(fpmc_pkg::OFS_STATUS);
    chk("status", 32'h17, rd);
    stop_test();
  end
endmodule
